// ==== core/ubw_bit_timer.sv ====
// Bit-time counter with one-clock lengthen or shorten
`timescale 1ns/1ps
`default_nettype none
module ubw_bit_timer #(
  parameter int CW = 16
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Bit control
  input  wire logic          bit_start,
  input  wire logic [CW-1:0] nominal_len,
  input  wire logic          compensate,
  input  wire logic          comp_direction,
  // Result
  output logic               bit_end
);

  if (CW < 2 || CW > 30) begin : g_chk
    $error("ubw_bit_timer: CW out of range");
  end

  typedef struct packed {
    logic          busy;
    logic [CW:0]   cnt;
    logic          done;
  } ubw_timer_state_t;

  ubw_timer_state_t st_q;
  ubw_timer_state_t st_d;
  logic [CW:0]      len;

  always_comb begin
    len = {1'b0, nominal_len};
    if (compensate && !comp_direction) begin
      len = len + (CW+1)'(1);
    end else if (compensate && comp_direction) begin
      len = len - (CW+1)'(1);
    end
    // Never below one clock, even when shortening a one-clock bit
    if (len < (CW+1)'(ubw_pkg::MIN_BIT_CLKS)) begin
      len = (CW+1)'(ubw_pkg::MIN_BIT_CLKS);
    end
    st_d      = st_q;
    st_d.done = 1'b0;
    if (bit_start) begin
      st_d.busy = 1'b1;
      // Full width, so a lengthened maximum bit does not wrap
      st_d.cnt  = len - (CW+1)'(1);
    end else if (st_q.busy) begin
      if (st_q.cnt == '0) begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt - (CW+1)'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bit_end = st_q.done;

endmodule
`default_nettype wire

// ==== core/ubw_pkg.sv ====
// Shared constants for the baud compensation and wake-up control slice
package ubw_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFF_COMP     = 8'h3C;
  localparam logic [7:0]  OFF_WAKE_EN  = 8'h40;
  localparam logic [7:0]  OFF_WAKE_STS = 8'h44;
  localparam logic [7:0]  OFF_IRQ_MASK = 8'h50;

  // ****************************************************
  // Field layout
  // ****************************************************
  localparam int COMP_DIR_BIT   = 31;
  localparam int COMP_PAT_W     = 9;
  localparam int PARITY_IDX     = 8;
  localparam int WAKE_N         = 5;
  localparam int WAKE_CTS       = 0;
  localparam int WAKE_DATA      = 1;
  localparam int WAKE_THRESHOLD = 2;
  localparam int WAKE_ADDR      = 3;
  localparam int WAKE_TIMEOUT   = 4;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [31:0] COMP_RST     = 32'h0000_0000;
  localparam logic [4:0]  WAKE_EN_RST  = 5'h00;
  localparam logic [4:0]  WAKE_STS_RST = 5'h00;
  localparam logic [4:0]  IRQ_MASK_RST = 5'h00;

  // ****************************************************
  // Bus answers and timing
  // ****************************************************
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
  localparam int          MIN_BIT_CLKS = 1;

endpackage

// ==== core/ubw_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ubw_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ubw_sync_state_t;

  ubw_sync_state_t st_q;
  ubw_sync_state_t st_d;

  // First stage feeds only the second
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= {RST_VAL, RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule
`default_nettype wire

// ==== core/ubw_top.sv ====
// Baud compensation and wake-up control with AXI4-Lite registers
//
// What this block does
// - Direction bit 0: each selected bit lasts one module clock longer.
// - Direction bit 1: each selected bit lasts one module clock shorter; a one-clock bit stays one clock.
// - Nine pattern bits pick which bit times get compensated.
// - Pattern bits 7..0 map to data bits 7..0; bit 8 to parity.
// - Enabled threshold time-out wakes the system during power-down.
// - Enabled address match wakes the system during power-down.
// - Address-match wake only counts in auto address detect mode.
// - Enabled FIFO threshold reached wakes the system during power-down.
// - Enabled incoming data wakes the system during power-down.
// - Enabled nCTS change wakes the system during power-down.
// - Each wake source sets its own status flag.
// - Wake flags stay set until software writes one to them.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ubw_top #(
  parameter int LEN_W = 16
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]       awaddr,
  input  wire logic [2:0]       awprot,
  input  wire logic             awvalid,
  output logic                  awready,
  // AXI4-Lite write data
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  input  wire logic             wvalid,
  output logic                  wready,
  // AXI4-Lite write response
  output logic      [1:0]       bresp,
  output logic                  bvalid,
  input  wire logic             bready,
  // AXI4-Lite read address
  input  wire logic [7:0]       araddr,
  input  wire logic [2:0]       arprot,
  input  wire logic             arvalid,
  output logic                  arready,
  // AXI4-Lite read data
  output logic      [31:0]      rdata,
  output logic      [1:0]       rresp,
  output logic                  rvalid,
  input  wire logic             rready,
  // Transmit and receive core bit timing
  input  wire logic             bit_start,
  input  wire logic [3:0]       bit_index,
  input  wire logic [LEN_W-1:0] baud_len,
  output logic                  bit_end,
  // Serial pins
  input  wire logic             cts_n_pin,
  input  wire logic             rx_pin,
  // Core status, same clock
  input  wire logic             power_down,
  input  wire logic             fifo_threshold_hit,
  input  wire logic             fifo_timeout_hit,
  input  wire logic             addr_match,
  input  wire logic             auto_addr_detect_mode,
  input  wire logic             addr_detect_en,
  // Power controller and interrupt
  output logic                  wake_req,
  output logic                  irq
);

  // Counter width must hold the longest bit time plus one
  if (LEN_W < 2 || LEN_W > 30) begin : g_chk
    $error("ubw_top: LEN_W out of range");
  end

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [7:0]  aw_addr;
    logic        aw_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_got;
    logic        b_valid;
    logic [1:0]  b_resp;
    logic        r_valid;
    logic [31:0] r_data;
    logic [1:0]  r_resp;
    logic        comp_direction;
    logic [8:0]  comp_pattern;
    logic [4:0]  wake_en;
    logic [4:0]  wake_sts;
    logic [4:0]  irq_mask;
    logic        cts_prev;
    logic        rx_prev;
    logic        wake_req;
    logic        irq;
  } ubw_state_t;

  ubw_state_t st_q;
  ubw_state_t st_d;

  logic [1:0] pin_sync;
  logic       cts_s;
  logic       rx_s;
  logic       compensate;
  logic [4:0] src;
  logic [4:0] evt;
  logic [4:0] clr;
  logic [31:0] old_word;
  logic [31:0] new_word;

  // ****************************************************
  // Pin synchronisers and bit timer
  // ****************************************************
  // Idle level is high on both pins, so reset to ones avoids a false edge
  ubw_sync #(
    .W       (2),
    .RST_VAL (2'b11)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({cts_n_pin, rx_pin}),
    .q       (pin_sync)
  );
  assign cts_s = pin_sync[1];
  assign rx_s  = pin_sync[0];

  // Only data bits 0..7 and the parity slot have a pattern bit
  always_comb begin
    compensate = 1'b0;
    if (bit_index <= 4'(ubw_pkg::PARITY_IDX)) begin
      compensate = st_q.comp_pattern[bit_index];
    end
  end

  // Pattern applies at bit start; a later write waits for the next bit
  ubw_bit_timer #(
    .CW             (LEN_W)
  ) u_timer (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .bit_start      (bit_start),
    .nominal_len    (baud_len),
    .compensate     (compensate),
    .comp_direction (st_q.comp_direction),
    .bit_end        (bit_end)
  );

  // ****************************************************
  // Byte-lane merge
  // ****************************************************
  // Byte lanes with a clear strobe keep their old contents
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************************
  // Wake sources
  // ****************************************************
  always_comb begin
    // Level sources re-fire on every cycle that they stay high
    src                            = '0;
    // Either nCTS edge counts; rx counts on every falling edge of the line
    src[ubw_pkg::WAKE_CTS]         = cts_s != st_q.cts_prev;
    src[ubw_pkg::WAKE_DATA]        = st_q.rx_prev && !rx_s;
    src[ubw_pkg::WAKE_THRESHOLD]   = fifo_threshold_hit;
    src[ubw_pkg::WAKE_ADDR]        = addr_match && auto_addr_detect_mode
                                     && addr_detect_en;
    // Time-out wake does not require threshold wake; software pairs them
    src[ubw_pkg::WAKE_TIMEOUT]     = fifo_timeout_hit;
    evt = src & st_q.wake_en & {5{power_down}};
  end

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    st_d     = st_q;
    clr      = '0;
    old_word = '0;
    new_word = '0;

    // Write channel: address and data in either order
    if (awvalid && awready) begin
      st_d.aw_addr = awaddr;
      st_d.aw_got  = 1'b1;
    end
    if (wvalid && wready) begin
      st_d.w_data = wdata;
      st_d.w_strb = wstrb;
      st_d.w_got  = 1'b1;
    end
    if (st_q.b_valid && bready) begin
      st_d.b_valid = 1'b0;
    end
    // Unmapped offsets change nothing and answer with an error
    // Reserved bits are dropped on write and read back as zero
    if (st_q.aw_got && st_q.w_got) begin
      st_d.aw_got  = 1'b0;
      st_d.w_got   = 1'b0;
      st_d.b_valid = 1'b1;
      st_d.b_resp  = ubw_pkg::RESP_OKAY;
      if (st_q.aw_addr == ubw_pkg::OFF_COMP) begin
        old_word = {st_q.comp_direction, 22'h00_0000, st_q.comp_pattern};
        new_word = merge(old_word, st_q.w_data, st_q.w_strb);
        st_d.comp_direction = new_word[ubw_pkg::COMP_DIR_BIT];
        st_d.comp_pattern   = new_word[ubw_pkg::COMP_PAT_W-1:0];
      end else if (st_q.aw_addr == ubw_pkg::OFF_WAKE_EN) begin
        old_word = {27'h000_0000, st_q.wake_en};
        new_word = merge(old_word, st_q.w_data, st_q.w_strb);
        st_d.wake_en = new_word[ubw_pkg::WAKE_N-1:0];
      end else if (st_q.aw_addr == ubw_pkg::OFF_WAKE_STS) begin
        new_word = merge(32'h0000_0000, st_q.w_data, st_q.w_strb);
        clr      = new_word[ubw_pkg::WAKE_N-1:0];
      end else if (st_q.aw_addr == ubw_pkg::OFF_IRQ_MASK) begin
        old_word = {27'h000_0000, st_q.irq_mask};
        new_word = merge(old_word, st_q.w_data, st_q.w_strb);
        st_d.irq_mask = new_word[ubw_pkg::WAKE_N-1:0];
      end else begin
        st_d.b_resp = ubw_pkg::RESP_SLVERR;
      end
    end

    // Read channel
    // One read in flight: arready stays low while rvalid stands
    if (st_q.r_valid && rready) begin
      st_d.r_valid = 1'b0;
    end
    if (arvalid && arready) begin
      st_d.r_valid = 1'b1;
      st_d.r_resp  = ubw_pkg::RESP_OKAY;
      if (araddr == ubw_pkg::OFF_COMP) begin
        st_d.r_data = {st_q.comp_direction, 22'h00_0000, st_q.comp_pattern};
      end else if (araddr == ubw_pkg::OFF_WAKE_EN) begin
        st_d.r_data = {27'h000_0000, st_q.wake_en};
      end else if (araddr == ubw_pkg::OFF_WAKE_STS) begin
        st_d.r_data = {27'h000_0000, st_q.wake_sts};
      end else if (araddr == ubw_pkg::OFF_IRQ_MASK) begin
        st_d.r_data = {27'h000_0000, st_q.irq_mask};
      end else begin
        st_d.r_data = 32'h0000_0000;
        st_d.r_resp = ubw_pkg::RESP_SLVERR;
      end
    end

    // Sticky flags: a new wake event beats a same-cycle clear
    st_d.wake_sts = (st_q.wake_sts & ~clr) | evt;
    st_d.wake_req = |evt;
    st_d.irq      = |(st_d.wake_sts & st_d.irq_mask);
    st_d.cts_prev = cts_s;
    st_d.rx_prev  = rx_s;
  end

  // ****************************************************
  // Registers
  // ****************************************************
  // Pin history starts at the idle level, so release shows no edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q                <= '0;
      st_q.comp_direction <= ubw_pkg::COMP_RST[ubw_pkg::COMP_DIR_BIT];
      st_q.comp_pattern   <= ubw_pkg::COMP_RST[ubw_pkg::COMP_PAT_W-1:0];
      st_q.wake_en        <= ubw_pkg::WAKE_EN_RST;
      st_q.wake_sts       <= ubw_pkg::WAKE_STS_RST;
      st_q.irq_mask       <= ubw_pkg::IRQ_MASK_RST;
      st_q.cts_prev       <= 1'b1;
      st_q.rx_prev        <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // Ready held low while a response waits, so one write at a time
  assign awready  = !st_q.aw_got && !st_q.b_valid;
  assign wready   = !st_q.w_got && !st_q.b_valid;
  assign arready  = !st_q.r_valid;
  assign bvalid   = st_q.b_valid;
  assign bresp    = st_q.b_resp;
  assign rvalid   = st_q.r_valid;
  assign rdata    = st_q.r_data;
  assign rresp    = st_q.r_resp;
  // Wake request lags its source by one clock but leaves a flop clean
  assign wake_req = st_q.wake_req;
  assign irq      = st_q.irq;

endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the compensation and wake-up slice
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************************
  // Signals
  // ****************************************************
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, bit_end, irq;
  logic        bit_start, power_down, fifo_threshold_hit, fifo_timeout_hit;
  logic        addr_match, auto_addr_detect_mode, addr_detect_en, wake_req;
  logic        cts_n_pin, rx_pin;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [3:0]  wstrb, bit_index;
  logic [1:0]  bresp, rresp;
  logic [31:0] wdata, rdata, val;
  logic [15:0] baud_len, len;
  logic [33:0] exp_q[$];
  int          len_q[$];
  int          bad_count, comparisons, cycles, cnt, e;
  ubw_top #(.LEN_W(16)) u_dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .bit_start, .bit_index, .baud_len, .bit_end, .cts_n_pin, .rx_pin,
    .power_down, .fifo_threshold_hit, .fifo_timeout_hit, .addr_match,
    .auto_addr_detect_mode, .addr_detect_en, .wake_req, .irq);
  ubw_remote u_remote (.aclk, .cts_n(cts_n_pin), .rx(rx_pin));
  initial aclk = 1'h0;
  always #20 aclk = ~aclk;
  task automatic check(input string what, input logic [33:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard well above the expected run length
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end
  // Results are taken in the order the drivers noted them
  always @(posedge aclk) begin
    if (rvalid && rready) check("read", {rresp, rdata}, exp_q.pop_front());
    if (bvalid && bready) check("bresp", {bresp, 32'h0000_0000}, exp_q.pop_front());
    if (bit_end) check("bit time", 34'(cnt), 34'(len_q.pop_front()));
    cnt = bit_start ? 0 : cnt + 1;
  end
  // ****************************************************
  // Bus and stimulus tasks
  // ****************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0000_0000});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid && bready));
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready));
    rready <= 1'h0;
  endtask
  task automatic bit_run(input logic [3:0] idx, input logic [15:0] l, input int x);
    len_q.push_back(x);
    @(posedge aclk);
    bit_start <= 1'h1;
    bit_index <= idx;
    baud_len <= l;
    @(posedge aclk);
    bit_start <= 1'h0;
    do begin
      @(posedge aclk);
    end while (!bit_end);
  endtask
  task automatic fire(input int s, input logic ew);
    if (s == 0) u_remote.flip_cts();
    else if (s == 1) u_remote.send_frame(8'($urandom));
    else begin
      @(posedge aclk);
      fifo_threshold_hit <= (s == 2);
      addr_match <= (s == 3);
      fifo_timeout_hit <= (s == 4);
      @(posedge aclk);
      {fifo_threshold_hit, addr_match, fifo_timeout_hit} <= 3'h0;
      @(negedge aclk);
      check("wake_req", wake_req, ew);
    end
    repeat (4) @(posedge aclk);
  endtask
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    void'($urandom(32'h9bb18066));
    {aresetn, awvalid, wvalid, bready, arvalid, rready, bit_start} = '0;
    {power_down, fifo_threshold_hit, fifo_timeout_hit, addr_match} = '0;
    {auto_addr_detect_mode, addr_detect_en, awaddr, araddr, wdata} = '0;
    {awprot, arprot, bit_index, baud_len} = '0;
    wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ubw_pkg::OFF_COMP, 32'h0000_0000, 2'h0);
    rd(ubw_pkg::OFF_WAKE_EN, 32'h0000_0000, 2'h0);
    rd(ubw_pkg::OFF_WAKE_STS, 32'h0000_0000, 2'h0);
    rd(ubw_pkg::OFF_IRQ_MASK, 32'h0000_0000, 2'h0);
    rd(8'h48, 32'h0000_0000, ubw_pkg::RESP_SLVERR);
    wr(8'h48, 32'hFFFF_FFFF, ubw_pkg::RESP_SLVERR);
    wr(ubw_pkg::OFF_WAKE_EN, 32'hFFFF_FFFF, 2'h0);
    rd(ubw_pkg::OFF_WAKE_EN, 32'h0000_001F, 2'h0);
    for (int dir = 0; dir < 2; dir++) begin
      val = {dir[0], 31'($urandom)};
      wr(ubw_pkg::OFF_COMP, val, 2'h0);
      rd(ubw_pkg::OFF_COMP, val & 32'h8000_01FF, 2'h0);
      for (int i = 0; i < 10; i++) begin
        len = 16'($urandom_range(3, 10));
        e = (i < 9 && val[i]) ? (dir ? len - 1 : len + 1) : len;
        bit_run(4'(i), len, e);
      end
    end
    wr(ubw_pkg::OFF_COMP, 32'h8000_0100, 2'h0);
    bit_run(4'h8, 16'h0001, 1);
    wr(ubw_pkg::OFF_IRQ_MASK, 32'h0000_001F, 2'h0);
    auto_addr_detect_mode <= 1'h1;
    addr_detect_en <= 1'h1;
    fire(2, 1'h0);
    rd(ubw_pkg::OFF_WAKE_STS, 32'h0000_0000, 2'h0);
    power_down <= 1'h1;
    for (int s = 0; s < 5; s++) begin
      val = 32'h0000_001F & ~(32'h0000_0001 << s);
      if (s == 2) val[4] = 1'h0;
      wr(ubw_pkg::OFF_WAKE_EN, val, 2'h0);
      fire(s, 1'h0);
      rd(ubw_pkg::OFF_WAKE_STS, 32'h0000_0000, 2'h0);
      wr(ubw_pkg::OFF_WAKE_EN, 32'h0000_001F, 2'h0);
      fire(s, 1'h1);
      rd(ubw_pkg::OFF_WAKE_STS, 32'h0000_0001 << s, 2'h0);
      check("irq", irq, 1'h1);
      wr(ubw_pkg::OFF_WAKE_STS, 32'h0000_0000, 2'h0);
      rd(ubw_pkg::OFF_WAKE_STS, 32'h0000_0001 << s, 2'h0);
      wr(ubw_pkg::OFF_WAKE_STS, 32'h0000_0001 << s, 2'h0);
      rd(ubw_pkg::OFF_WAKE_STS, 32'h0000_0000, 2'h0);
      check("irq", irq, 1'h0);
    end
    addr_detect_en <= 1'h0;
    fire(3, 1'h0);
    rd(ubw_pkg::OFF_WAKE_STS, 32'h0000_0000, 2'h0);
    wr(ubw_pkg::OFF_IRQ_MASK, 32'h0000_0000, 2'h0);
    fire(4, 1'h1);
    rd(ubw_pkg::OFF_WAKE_STS, 32'h0000_0010, 2'h0);
    check("irq", irq, 1'h0);
    test_done();
  end
endmodule
`default_nettype wire

// ==== test/ubw_props.sv ====
// Checker for the compensation and wake-up slice
`timescale 1ns/1ps
`default_nettype none
module ubw_props #(
  parameter int LEN_W = 16
) (
  // Clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // Register bus
  input wire logic             awvalid,
  input wire logic             awready,
  input wire logic             wvalid,
  input wire logic             wready,
  input wire logic [1:0]       bresp,
  input wire logic             bvalid,
  input wire logic             bready,
  input wire logic             arvalid,
  input wire logic             arready,
  input wire logic [31:0]      rdata,
  input wire logic             rvalid,
  input wire logic             rready,
  // Bit timing
  input wire logic             bit_start,
  input wire logic [3:0]       bit_index,
  input wire logic [LEN_W-1:0] baud_len,
  input wire logic             bit_end,
  // Wake sources and request
  input wire logic             cts_n_pin,
  input wire logic             rx_pin,
  input wire logic             power_down,
  input wire logic             fifo_threshold_hit,
  input wire logic             fifo_timeout_hit,
  input wire logic             addr_match,
  input wire logic             auto_addr_detect_mode,
  input wire logic             addr_detect_en,
  input wire logic             wake_req
);
  // ****************************************************
  // Bit length tracking
  // ****************************************************
  logic [LEN_W:0]   cnt_q;
  logic [LEN_W-1:0] len_q;
  logic             unc_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      len_q <= '0;
      unc_q <= 1'h1;
    end else if (bit_start) begin
      cnt_q <= '0;
      len_q <= baud_len;
      unc_q <= bit_index > 4'h8;
    end else begin
      cnt_q <= cnt_q + 1'h1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_IDLE_NO_WAKE: assert property (!power_down |=> !wake_req)
    else $error("wake request outside power-down");
  AST_WAKE_CAUSE: assert property (wake_req |-> $past(power_down) &&
    ($past(fifo_threshold_hit) || $past(fifo_timeout_hit) ||
     $past(addr_match && auto_addr_detect_mode && addr_detect_en) ||
     $past(cts_n_pin, 3) != $past(cts_n_pin, 4) ||
     ($past(rx_pin, 4) && !$past(rx_pin, 3))))
    else $error("wake request without a source");
  AST_BIT_NOMINAL: assert property (bit_end && unc_q |-> cnt_q == len_q)
    else $error("uncompensated bit has wrong length");
  AST_BIT_ADJUST: assert property (bit_end && len_q > 1 |->
    cnt_q + 1'h1 >= len_q && cnt_q <= len_q + 1'h1)
    else $error("bit length off by more than one clock");
  AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  AST_WR_ANSWER: assert property
    (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  AST_B_STANDS: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_STANDS: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_AR_BLOCK: assert property (rvalid |-> !arready)
    else $error("read address taken while busy");
  cover property (wake_req);
  cover property (bit_end && !unc_q && cnt_q != len_q);
  cover property (bvalid && bresp == ubw_pkg::RESP_SLVERR);
endmodule
bind ubw_top ubw_props #(.LEN_W(LEN_W)) u_props (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready,
  .rdata, .rvalid, .rready, .bit_start, .bit_index, .baud_len, .bit_end,
  .cts_n_pin, .rx_pin, .power_down, .fifo_threshold_hit, .fifo_timeout_hit,
  .addr_match, .auto_addr_detect_mode, .addr_detect_en, .wake_req);
`default_nettype wire

// ==== test/ubw_remote.sv ====
// Remote serial device model driving the handshake and data pins
`timescale 1ns/1ps
`default_nettype none
module ubw_remote #(
  parameter int BIT_CLKS = 3
) (
  // Clock
  input  wire logic aclk,
  // Serial pins, idle high through pull-ups
  output logic      cts_n,
  output logic      rx
);
  initial begin
    cts_n = 1'h1;
    rx = 1'h1;
  end
  task automatic flip_cts();
    @(posedge aclk);
    cts_n <= ~cts_n;
  endtask
  // Stop bit leaves the line at its idle level
  task automatic send_frame(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      rx <= f[i];
      repeat (BIT_CLKS - 1) @(posedge aclk);
    end
  endtask
endmodule
`default_nettype wire
